// ==== logic/mdu_engine.sv ====
`timescale 1ns/100ps
// Sequential engine: shift-and-add multiply and restoring divide, two steps a clock.
module mdu_engine import mdu_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic divide,
  input wire mdu_data_t din,
  output mdu_data_t dout,
  output logic done
);

  typedef struct packed {
    mdu_state_t state;
    logic [4:0] count;
    logic div;
    logic [31:0] acc;
    logic [16:0] rem;
    logic [15:0] opnd;
    logic [31:0] prod;
  } mdu_eng_t;

  mdu_eng_t cur;
  mdu_eng_t next_cur;

  // Each divide cycle performs two single-bit steps, so 32 steps finish in 16 cycles; multiply does its 16 steps in the first 8.
  always_comb begin
    logic [16:0] trial;
    logic [31:0] addend;
    trial = '0;
    addend = '0;
    next_cur = cur;
    unique case (cur.state)
      MDU_IDLE, MDU_DONE: begin
        next_cur.state = MDU_IDLE;
        if (start) begin
          next_cur.state = MDU_BUSY;
          next_cur.count = '0;
          next_cur.div = divide;
          next_cur.acc = din.accum;
          next_cur.opnd = din.operand;
          next_cur.rem = '0;
          next_cur.prod = '0;
        end
      end
      MDU_BUSY: begin
        for (int i = 0; i < 2; i++) begin
          if (next_cur.div) begin
            // Restoring division: bring in the next dividend bit.
            trial = {next_cur.rem[15:0], next_cur.acc[31]};
            next_cur.acc = {next_cur.acc[30:0], 1'b0};
            if (trial >= {1'b0, next_cur.opnd}) begin
              trial = trial - {1'b0, next_cur.opnd};
              next_cur.acc[0] = 1'b1;
            end
            next_cur.rem = trial;
          end else if (next_cur.count < 5'd8) begin
            // Multiply on 16 steps, low operand bit first.
            addend = next_cur.opnd[0] ? (32'(next_cur.acc[15:0]) << (2 * next_cur.count + i))
                                      : 32'h0;
            next_cur.prod = next_cur.prod + addend;
            next_cur.opnd = {1'b0, next_cur.opnd[15:1]};
          end
        end
        next_cur.count = cur.count + 5'd1;
        if (cur.count == MDU_OP_CYCLES - 5'd1) begin
          next_cur.state = MDU_DONE;
        end
      end
      default: next_cur.state = MDU_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Results: quotient and remainder for divide, the full product for multiply.
  // They come from the last step's next value, so the write-back lands on the sixteenth
  // edge; a registered done would stretch the busy span to seventeen clocks.
  assign dout.accum = next_cur.div ? next_cur.acc : next_cur.prod;
  assign dout.operand = next_cur.div ? next_cur.rem[15:0] : MDU_OPERAND_RESET;
  assign done = (cur.state == MDU_BUSY) && (cur.count == MDU_OP_CYCLES - 5'd1);

endmodule // mdu_engine

// ==== logic/mdu_unit.sv ====
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
// Summary of operation
// - Unsigned 16x16 multiply to 32 bits and 32/16 divide in hardware.
// - Writing one to the start bit while idle begins an operation; writing zero does nothing.
// - Start bit reads one while busy and clears when the result is ready.
// - Select zero: accumulator bytes 1:0 times operand give product in bytes 3:0.
// - Select one: accumulator divided by operand; quotient to accumulator, remainder to operand.
// - Each operation completes within 16 system clocks of its trigger.
module mdu_unit import mdu_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic busy,
  output logic checksum_start_bit
);

  typedef struct packed {
    logic [31:0] wide_accumulator;
    logic [15:0] operand_register;
    logic op_start_bit;
    logic op_select_bit;
    logic checksum_start_bit;
    logic [7:0] rdata;
  } mdu_regs_t;

  mdu_regs_t cur;
  mdu_regs_t next_cur;
  mdu_bus_req_t req;
  mdu_data_t eng_in;
  mdu_data_t eng_out;
  logic eng_done;
  logic start_pulse;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign eng_in = '{accum: cur.wide_accumulator, operand: cur.operand_register};

  // A one written to the start bit while idle triggers the engine.
  assign start_pulse = req.wr && (req.addr == ARITH_CONTROL_ADDR) &&
                       req.wdata[OP_START_BIT_POS] && !cur.op_start_bit;

  mdu_engine u_engine (
    .clk(clk),
    .rst(rst),
    .start(start_pulse),
    .divide(cur.op_select_bit),
    .din(eng_in),
    .dout(eng_out),
    .done(eng_done)
  );

  // Register writes, completion write-back and the registered read port.
  always_comb begin
    next_cur = cur;
    next_cur.rdata = MDU_READ_IDLE;
    if (req.wr) begin
      unique case (req.addr)
        MDU_ACCUM_BYTE0_ADDR: next_cur.wide_accumulator[7:0] = req.wdata;
        MDU_ACCUM_BYTE1_ADDR: next_cur.wide_accumulator[15:8] = req.wdata;
        MDU_ACCUM_BYTE2_ADDR: next_cur.wide_accumulator[23:16] = req.wdata;
        MDU_ACCUM_BYTE3_ADDR: next_cur.wide_accumulator[31:24] = req.wdata;
        MDU_OPERAND_LOW_ADDR: next_cur.operand_register[7:0] = req.wdata;
        MDU_OPERAND_HIGH_ADDR: next_cur.operand_register[15:8] = req.wdata;
        ARITH_CONTROL_ADDR: begin
          // The select bit is frozen mid-operation so the result matches the trigger.
          if (!cur.op_start_bit) begin
            next_cur.op_select_bit = req.wdata[OP_SELECT_BIT_POS];
          end
          next_cur.checksum_start_bit = req.wdata[CHECKSUM_START_BIT_POS];
          if (start_pulse) begin
            next_cur.op_start_bit = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Completion overrides stray accumulator writes, and operand writes for divide, since software must stay off while busy.
    if (eng_done) begin
      next_cur.wide_accumulator = eng_out.accum;
      if (cur.op_select_bit) begin
        next_cur.operand_register = eng_out.operand;
      end
      next_cur.op_start_bit = 1'b0;
    end
    if (req.rd) begin
      unique case (req.addr)
        MDU_ACCUM_BYTE0_ADDR: next_cur.rdata = cur.wide_accumulator[7:0];
        MDU_ACCUM_BYTE1_ADDR: next_cur.rdata = cur.wide_accumulator[15:8];
        MDU_ACCUM_BYTE2_ADDR: next_cur.rdata = cur.wide_accumulator[23:16];
        MDU_ACCUM_BYTE3_ADDR: next_cur.rdata = cur.wide_accumulator[31:24];
        MDU_OPERAND_LOW_ADDR: next_cur.rdata = cur.operand_register[7:0];
        MDU_OPERAND_HIGH_ADDR: next_cur.rdata = cur.operand_register[15:8];
        ARITH_CONTROL_ADDR: begin
          next_cur.rdata[OP_START_BIT_POS] = cur.op_start_bit;
          next_cur.rdata[OP_SELECT_BIT_POS] = cur.op_select_bit;
          next_cur.rdata[CHECKSUM_START_BIT_POS] = cur.checksum_start_bit;
        end
        default: next_cur.rdata = MDU_READ_IDLE;
      endcase
    end
  end

  // Reset clears every byte and control bit.
  always_ff @(posedge clk) begin
    if (rst) begin
      cur.wide_accumulator <= MDU_ACCUM_RESET;
      cur.operand_register <= MDU_OPERAND_RESET;
      cur.op_start_bit <= 1'b0;
      cur.op_select_bit <= 1'b0;
      cur.checksum_start_bit <= 1'b0;
      cur.rdata <= MDU_READ_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign busy = cur.op_start_bit;
  assign checksum_start_bit = cur.checksum_start_bit;

endmodule // mdu_unit

// ==== pkg/mdu_pkg.sv ====
package mdu_pkg;

  // Register offsets in the special function register space.
  localparam logic [7:0] MDU_ACCUM_BYTE0_ADDR = 8'he9;
  localparam logic [7:0] MDU_ACCUM_BYTE1_ADDR = 8'hea;
  localparam logic [7:0] MDU_ACCUM_BYTE2_ADDR = 8'heb;
  localparam logic [7:0] MDU_ACCUM_BYTE3_ADDR = 8'hec;
  localparam logic [7:0] MDU_OPERAND_LOW_ADDR = 8'hed;
  localparam logic [7:0] MDU_OPERAND_HIGH_ADDR = 8'hee;
  localparam logic [7:0] ARITH_CONTROL_ADDR = 8'hef;

  // Field positions in the arithmetic control register.
  localparam int OP_START_BIT_POS = 7;
  localparam int OP_SELECT_BIT_POS = 6;
  localparam int CHECKSUM_START_BIT_POS = 0;

  // Reset values.
  localparam logic [31:0] MDU_ACCUM_RESET = 32'h0000_0000;
  localparam logic [15:0] MDU_OPERAND_RESET = 16'h0000;
  localparam logic [7:0] MDU_READ_IDLE = 8'h00;

  // Operation time: 16 system clocks at 100 MHz.
  localparam int MDU_CLK_PERIOD_NS = 10;
  localparam int MDU_OP_TIME_NS = 160;
  localparam int MDU_OP_CYCLES_INT = MDU_OP_TIME_NS / MDU_CLK_PERIOD_NS;
  localparam logic [4:0] MDU_OP_CYCLES = 5'(MDU_OP_CYCLES_INT);

  typedef enum logic [1:0] {
    MDU_IDLE = 2'b00,
    MDU_BUSY = 2'b01,
    MDU_DONE = 2'b10
  } mdu_state_t;

  // Register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mdu_bus_req_t;

  // Operand and result set carried between the register file and the engine.
  typedef struct packed {
    logic [31:0] accum;
    logic [15:0] operand;
  } mdu_data_t;

endpackage

// ==== verif/mdu_checker_assertions.sv ====
`timescale 1ns/100ps
// Watches the register port, busy flag and checksum bit of the arithmetic unit.
module mdu_checker import mdu_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic busy,
  input wire logic checksum_start_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic ctl_wr;
  // Control writes are decoded once so every property sees the same condition.
  assign ctl_wr = reg_wr && reg_addr == ARITH_CONTROL_ADDR;
  a_start_sets_busy: assert property (ctl_wr && reg_wdata[7] && !busy |=> busy)
    else $error("start write did not raise busy");
  a_zero_no_start: assert property (ctl_wr && !reg_wdata[7] && !busy |=> !busy)
    else $error("zero start bit began an operation");
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:16] !busy)
    else $error("operation ran past sixteen clocks");
  a_busy_holds: assert property ($rose(busy) |=> busy[*8])
    else $error("busy dropped too early");
  a_ctl_readback: assert property (reg_rd && reg_addr == ARITH_CONTROL_ADDR |=>
    reg_rdata[5:1] == 5'h00 && reg_rdata[0] == checksum_start_bit)
    else $error("control readback wrong");
  a_cksum_write: assert property (ctl_wr |=> checksum_start_bit == $past(reg_wdata[0]))
    else $error("checksum bit not written");
  a_unmapped_zero: assert property (reg_rd && reg_addr < 8'he9 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !busy && !checksum_start_bit)
    else $error("reset left control bits set");
  // A completed operation, a checksum write and a control read are the main cases.
  cover property ($fell(busy));
  cover property (ctl_wr && reg_wdata[0]);
  cover property (reg_rd && reg_addr == ARITH_CONTROL_ADDR);
endmodule // mdu_checker

bind mdu_unit mdu_checker i_mdu_checker (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .busy, .checksum_start_bit);

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
// Drives corner and random multiply and divide operations through the register port.
module tb_top import mdu_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic busy;
  logic checksum_start_bit;
  int n_fail = 0;
  int compares = 0;
  // Free-running system clock.
  always #5 clk = ~clk;
  mdu_unit i_mdu_unit (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .busy,
    .checksum_start_bit);
  // Case inequality, so an unknown never passes for a match.
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Operand in the top 16 bits, accumulator in the low 32.
  task automatic rd_all(output logic [47:0] v);
    for (int i = 0; i < 6; i++) rd(MDU_ACCUM_BYTE0_ADDR + 8'(i), v[8*i +: 8]);
  endtask
  function automatic logic [47:0] calc(input logic dv, input logic [31:0] a, input logic [15:0] b);
    if (!dv) return {b, 32'(a[15:0]) * 32'(b)};
    if (b == 16'h0000) return {a[15:0], 32'hffff_ffff};
    return {16'(a % 32'(b)), a / 32'(b)};
  endfunction
  // Select is written before start, since start alone uses the stored select.
  task automatic run_op(input logic dv, input logic [31:0] a, input logic [15:0] b);
    logic [47:0] v;
    logic [7:0] d;
    int n;
    v = {b, a};
    for (int i = 0; i < 6; i++) wr(MDU_ACCUM_BYTE0_ADDR + 8'(i), v[8*i +: 8]);
    wr(ARITH_CONTROL_ADDR, {1'b0, dv, 6'h00});
    wr(ARITH_CONTROL_ADDR, {1'b1, dv, 6'h00});
    #1 check(busy, 1'b1);
    n = 0;
    // Registers stay untouched until the start bit drops.
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    check(n <= 16, 1'b1);
    rd(ARITH_CONTROL_ADDR, d);
    check(d, {1'b0, dv, 6'h00});
    rd_all(v);
    check(v, calc(dv, a, b));
    $display("op done div=%0d a=%h b=%h", dv, a, b);
  endtask
  task automatic complete_run;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence: reset values, trigger bit, corners, then random operations.
  initial begin
    logic [47:0] v;
    logic [7:0] d;
    void'($urandom(32'ha677c9c2));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_all(v);
    check(v, 48'h0);
    rd(ARITH_CONTROL_ADDR, d);
    check(d, 8'h00);
    rd(8'h00, d);
    check(d, 8'h00);
    wr(ARITH_CONTROL_ADDR, 8'h01);
    #1 check(busy, 1'b0);
    check(checksum_start_bit, 1'b1);
    $display("reset and trigger test done");
    run_op(1'b0, 32'hffff_ffff, 16'hffff);
    run_op(1'b1, 32'hffff_ffff, 16'h0001);
    run_op(1'b1, 32'h1234_5678, 16'h0000);
    run_op(1'b1, 32'h0000_0005, 16'h0007);
    repeat (30) run_op(1'($urandom), $urandom, 16'($urandom));
    wr(MDU_ACCUM_BYTE3_ADDR, 8'h5a);
    rd(MDU_ACCUM_BYTE3_ADDR, d);
    check(d, 8'h5a);
    complete_run;
  end
  // About 35 operations of 46 clocks each; twelve times that covers any slow run.
  initial begin
    #200_000;
    n_fail++;
    complete_run;
  end
endmodule // tb_top
